//--- arr_params.svh
`ifndef ARR_PARAMS_SVH
`define ARR_PARAMS_SVH

// register byte offsets
`define ARR_OFS_SLOT6       8'h00
`define ARR_OFS_SLOT7       8'h04
`define ARR_OFS_PRIO        8'h08
`define ARR_OFS_INT_STATUS  8'h0C
`define ARR_OFS_INT_CLEAR   8'h10
`define ARR_OFS_INT_ENABLE  8'h14
`define ARR_OFS_PRIO_CTRL   8'h18

// result word layout
`define ARR_VALUE_LSB       6
`define ARR_VALUE_MSB       15
`define ARR_OVERRUN_BIT     1
`define ARR_STORED_BIT      0

// interrupt status layout
`define ARR_EV_SLOT6_STORED 0
`define ARR_EV_SLOT6_OVR    1
`define ARR_EV_SLOT7_STORED 2
`define ARR_EV_SLOT7_OVR    3
`define ARR_EV_PRIO_STORED  4
`define ARR_EV_PRIO_OVR     5

// priority control layout
`define ARR_PCTL_CH_LSB     0
`define ARR_PCTL_CH_MSB     3
`define ARR_PCTL_START_BIT  8
`define ARR_PCTL_BUSY_BIT   9

// slot codes carried on the normal result write
`define ARR_SLOT6           3'h6
`define ARR_SLOT7           3'h7

// reset values
`define ARR_RESULT_RST      10'h000
`define ARR_INT_RST         6'h00
`define ARR_CH_RST          4'h0

// bus answers
`define ARR_RESP_OKAY       2'h0
`define ARR_RESP_SLVERR     2'h2

`endif

//--- arr_pkg.sv
package arr_pkg;

	typedef enum {
		ARR_SEL_SLOT6,
		ARR_SEL_SLOT7,
		ARR_SEL_PRIO,
		ARR_SEL_INT_STATUS,
		ARR_SEL_INT_CLEAR,
		ARR_SEL_INT_ENABLE,
		ARR_SEL_PRIO_CTRL,
		ARR_SEL_NONE
	} arr_sel_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  slot;
		logic [9:0]  value;
	} arr_norm_wr_t;

	typedef struct packed {
		logic        valid;
		logic [9:0]  value;
	} arr_prio_wr_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  channel;
	} arr_prio_req_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} arr_reg_wr_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  addr;
	} arr_reg_rd_t;

	typedef struct packed {
		logic [9:0]  value;
		logic        stored;
		logic        overrun;
	} arr_slot_state_t;

	typedef struct packed {
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} arr_axil_state_t;

	typedef struct packed {
		logic [5:0]  int_status;
		logic [5:0]  int_enable;
		logic [3:0]  prio_channel;
		logic        prio_busy;
		logic        prio_req_valid;
		logic [3:0]  prio_req_channel;
	} arr_top_state_t;

endpackage

//--- arr_result_slot.sv
`timescale 1ns/1ps
`include "arr_params.svh"

module arr_result_slot
(
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic                    wr_valid,
	input  wire logic [9:0]              wr_value,
	input  wire logic                    rd_clr,
	output arr_pkg::arr_slot_state_t     state,
	output logic                         stored_evt,
	output logic                         overrun_evt
);
	import arr_pkg::*;

	arr_slot_state_t st;
	arr_slot_state_t next_st;

	// an overwrite counts as overrun only if the old value was not read in this cycle
	assign stored_evt  = wr_valid;
	assign overrun_evt = wr_valid && st.stored && !rd_clr;
	assign state       = st;

	always_comb
	begin
		next_st = st;
		if (rd_clr)
		begin
			next_st.stored  = 1'b0;
			next_st.overrun = 1'b0;
		end
		// the new result wins over a read clear in the same cycle
		if (wr_valid)
		begin
			next_st.value  = wr_value;
			next_st.stored = 1'b1;
			if (overrun_evt)
			begin
				next_st.overrun = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '{value: `ARR_RESULT_RST, stored: 1'b0, overrun: 1'b0};
		end
		else
		begin
			st <= next_st;
		end
	end

endmodule

//--- arr_axil_slave.sv
`timescale 1ns/1ps
`include "arr_params.svh"

module arr_axil_slave
#(
	parameter int ADDR_WIDTH = 8
)
(
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [ADDR_WIDTH-1:0]   s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [ADDR_WIDTH-1:0]   s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	output arr_pkg::arr_reg_wr_t         reg_wr,
	output arr_pkg::arr_reg_rd_t         reg_rd,
	input  wire logic                    wr_err,
	input  wire logic [31:0]             rd_data,
	input  wire logic                    rd_err
);
	import arr_pkg::*;

	arr_axil_state_t st;
	arr_axil_state_t next_st;
	logic            aw_take;
	logic            w_take;
	logic            ar_take;

	// addresses above the 8-bit window are folded into an unmapped code
	function automatic logic [7:0] arr_fold(input logic [ADDR_WIDTH-1:0] a);
		logic [31:0] wide;
		wide = 32'(a);
		arr_fold = (wide[31:8] != 24'h000000) ? 8'hFF : wide[7:0];
	endfunction

	assign s_axi_awready = !st.aw_held && !st.bvalid;
	assign s_axi_wready  = !st.w_held && !st.bvalid;
	assign s_axi_arready = !st.rvalid;
	assign aw_take       = s_axi_awvalid && s_axi_awready;
	assign w_take        = s_axi_wvalid && s_axi_wready;
	assign ar_take       = s_axi_arvalid && s_axi_arready;

	assign reg_wr = '{valid: st.aw_held && st.w_held && !st.bvalid,
		addr: st.aw_addr, data: st.w_data, strb: st.w_strb};
	// read side effects happen on the address handshake itself
	assign reg_rd = '{valid: ar_take, addr: arr_fold(s_axi_araddr)};

	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp  = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata  = st.rdata;
	assign s_axi_rresp  = st.rresp;

	always_comb
	begin
		next_st = st;
		if (aw_take)
		begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = arr_fold(s_axi_awaddr);
		end
		if (w_take)
		begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (reg_wr.valid)
		begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = wr_err ? `ARR_RESP_SLVERR : `ARR_RESP_OKAY;
		end
		if (st.bvalid && s_axi_bready)
		begin
			next_st.bvalid = 1'b0;
		end
		if (ar_take)
		begin
			next_st.rvalid = 1'b1;
			next_st.rdata  = rd_data;
			next_st.rresp  = rd_err ? `ARR_RESP_SLVERR : `ARR_RESP_OKAY;
		end
		else if (st.rvalid && s_axi_rready)
		begin
			next_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// refused at elaboration: the fold needs at least the 8-bit window
	if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32)
	begin : g_width_check
		$error("arr_axil_slave: ADDR_WIDTH must lie in 8..32");
	end

endmodule

//--- arr_result_regs.sv
`timescale 1ns/1ps
`include "arr_params.svh"

module arr_result_regs
#(
	parameter int ADDR_WIDTH = 8
)
(
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [ADDR_WIDTH-1:0]   s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [ADDR_WIDTH-1:0]   s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire arr_pkg::arr_norm_wr_t   norm_wr,
	input  wire arr_pkg::arr_prio_wr_t   prio_wr,
	output arr_pkg::arr_prio_req_t       prio_req,
	output logic                         irq
);
	import arr_pkg::*;

	arr_top_state_t  st;
	arr_top_state_t  next_st;
	arr_reg_wr_t     reg_wr;
	arr_reg_rd_t     reg_rd;
	arr_sel_t        wr_sel;
	arr_sel_t        rd_sel;
	arr_slot_state_t slot6;
	arr_slot_state_t slot7;
	arr_slot_state_t prio;
	logic            slot6_wr;
	logic            slot7_wr;
	logic            slot6_clr;
	logic            slot7_clr;
	logic            prio_clr;
	logic [5:0]      events;
	logic            slot6_st_ev;
	logic            slot6_ov_ev;
	logic            slot7_st_ev;
	logic            slot7_ov_ev;
	logic            prio_st_ev;
	logic            prio_ov_ev;
	logic [31:0]     rd_data;
	logic            rd_err;
	logic            wr_err;
	logic            start_hit;

	function automatic arr_sel_t arr_decode(input logic [7:0] a);
		case (a)
			`ARR_OFS_SLOT6:      arr_decode = ARR_SEL_SLOT6;
			`ARR_OFS_SLOT7:      arr_decode = ARR_SEL_SLOT7;
			`ARR_OFS_PRIO:       arr_decode = ARR_SEL_PRIO;
			`ARR_OFS_INT_STATUS: arr_decode = ARR_SEL_INT_STATUS;
			`ARR_OFS_INT_CLEAR:  arr_decode = ARR_SEL_INT_CLEAR;
			`ARR_OFS_INT_ENABLE: arr_decode = ARR_SEL_INT_ENABLE;
			`ARR_OFS_PRIO_CTRL:  arr_decode = ARR_SEL_PRIO_CTRL;
			default:             arr_decode = ARR_SEL_NONE;
		endcase
	endfunction

	// packs one result slot into its bus word
	function automatic logic [31:0] arr_result_word(input arr_slot_state_t s);
		logic [31:0] w;
		w = 32'h00000000;
		w[`ARR_VALUE_MSB:`ARR_VALUE_LSB] = s.value;
		w[`ARR_OVERRUN_BIT] = s.overrun;
		w[`ARR_STORED_BIT]  = s.stored;
		arr_result_word = w;
	endfunction

	arr_axil_slave #(
		.ADDR_WIDTH (ADDR_WIDTH)
	) u_bus (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.wr_err        (wr_err),
		.rd_data       (rd_data),
		.rd_err        (rd_err)
	);

	assign wr_sel = arr_decode(reg_wr.addr);
	assign rd_sel = arr_decode(reg_rd.addr);

	// routing of finished normal conversions by slot code
	assign slot6_wr = norm_wr.valid && (norm_wr.slot == `ARR_SLOT6);
	assign slot7_wr = norm_wr.valid && (norm_wr.slot == `ARR_SLOT7);

	// one word read covers value and both flags, so it clears both
	assign slot6_clr = reg_rd.valid && (rd_sel == ARR_SEL_SLOT6);
	assign slot7_clr = reg_rd.valid && (rd_sel == ARR_SEL_SLOT7);
	assign prio_clr  = reg_rd.valid && (rd_sel == ARR_SEL_PRIO);

	arr_result_slot u_slot6 (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.wr_valid    (slot6_wr),
		.wr_value    (norm_wr.value),
		.rd_clr      (slot6_clr),
		.state       (slot6),
		.stored_evt  (slot6_st_ev),
		.overrun_evt (slot6_ov_ev)
	);

	arr_result_slot u_slot7 (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.wr_valid    (slot7_wr),
		.wr_value    (norm_wr.value),
		.rd_clr      (slot7_clr),
		.state       (slot7),
		.stored_evt  (slot7_st_ev),
		.overrun_evt (slot7_ov_ev)
	);

	// separate instance keeps priority overruns apart from normal slots
	arr_result_slot u_prio (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.wr_valid    (prio_wr.valid),
		.wr_value    (prio_wr.value),
		.rd_clr      (prio_clr),
		.state       (prio),
		.stored_evt  (prio_st_ev),
		.overrun_evt (prio_ov_ev)
	);

	always_comb
	begin
		events = 6'h00;
		events[`ARR_EV_SLOT6_STORED] = slot6_st_ev;
		events[`ARR_EV_SLOT6_OVR]    = slot6_ov_ev;
		events[`ARR_EV_SLOT7_STORED] = slot7_st_ev;
		events[`ARR_EV_SLOT7_OVR]    = slot7_ov_ev;
		events[`ARR_EV_PRIO_STORED]  = prio_st_ev;
		events[`ARR_EV_PRIO_OVR]     = prio_ov_ev;
	end

	// read mux; result writes are accepted and dropped
	always_comb
	begin
		rd_data = 32'h00000000;
		rd_err  = 1'b0;
		case (rd_sel)
			ARR_SEL_SLOT6:      rd_data = arr_result_word(slot6);
			ARR_SEL_SLOT7:      rd_data = arr_result_word(slot7);
			ARR_SEL_PRIO:       rd_data = arr_result_word(prio);
			ARR_SEL_INT_STATUS: rd_data = {26'h0, st.int_status};
			ARR_SEL_INT_CLEAR:  rd_data = 32'h00000000;
			ARR_SEL_INT_ENABLE: rd_data = {26'h0, st.int_enable};
			ARR_SEL_PRIO_CTRL:
			begin
				rd_data[`ARR_PCTL_CH_MSB:`ARR_PCTL_CH_LSB] = st.prio_channel;
				rd_data[`ARR_PCTL_BUSY_BIT] = st.prio_busy;
			end
			default:            rd_err = 1'b1;
		endcase
	end

	assign wr_err    = (wr_sel == ARR_SEL_NONE);
	assign start_hit = reg_wr.valid && (wr_sel == ARR_SEL_PRIO_CTRL) && reg_wr.strb[1]
		&& reg_wr.data[`ARR_PCTL_START_BIT];

	always_comb
	begin
		next_st = st;
		next_st.prio_req_valid = 1'b0;
		// set wins over a clear landing in the same cycle
		next_st.int_status = st.int_status;
		if (reg_wr.valid && (wr_sel == ARR_SEL_INT_CLEAR) && reg_wr.strb[0])
		begin
			next_st.int_status = st.int_status & ~reg_wr.data[5:0];
		end
		next_st.int_status = next_st.int_status | events;
		if (reg_wr.valid && (wr_sel == ARR_SEL_INT_ENABLE) && reg_wr.strb[0])
		begin
			next_st.int_enable = reg_wr.data[5:0];
		end
		if (reg_wr.valid && (wr_sel == ARR_SEL_PRIO_CTRL) && reg_wr.strb[0])
		begin
			next_st.prio_channel = reg_wr.data[`ARR_PCTL_CH_MSB:`ARR_PCTL_CH_LSB];
		end
		if (prio_wr.valid)
		begin
			next_st.prio_busy = 1'b0;
		end
		// a start while one is pending is ignored; no repeat or scan here
		if (start_hit && !st.prio_busy)
		begin
			next_st.prio_busy        = 1'b1;
			next_st.prio_req_valid   = 1'b1;
			next_st.prio_req_channel = (reg_wr.strb[0]) ?
				reg_wr.data[`ARR_PCTL_CH_MSB:`ARR_PCTL_CH_LSB] : st.prio_channel;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '{int_status: `ARR_INT_RST, int_enable: `ARR_INT_RST,
				prio_channel: `ARR_CH_RST, prio_busy: 1'b0,
				prio_req_valid: 1'b0, prio_req_channel: `ARR_CH_RST};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign prio_req = '{valid: st.prio_req_valid, channel: st.prio_req_channel};
	assign irq      = |(st.int_status & st.int_enable);

endmodule

//--- arr_seq_model.sv
`timescale 1ns/1ps
module arr_seq_model
(
	input  wire logic                   aclk,
	input  wire arr_pkg::arr_prio_req_t prio_req,
	output arr_pkg::arr_norm_wr_t       norm_wr,
	output arr_pkg::arr_prio_wr_t       prio_wr
);
	import arr_pkg::*;
	int         lat = 1;
	int         n_req = 0;
	logic [9:0] pval = 10'h000;
	logic [3:0] ch_seen = 4'h0;
	initial
	begin
		norm_wr = '0;
		prio_wr = '0;
	end
	// one pulse per finished conversion; idle value differs from the last one
	task conv(input logic [2:0] s, input logic [9:0] v);
	begin
		@(posedge aclk);
		norm_wr <= {1'h1, s, v};
		@(posedge aclk);
		norm_wr <= {1'h0, s, ~v};
	end
	endtask
	// single conversion on the requested channel, slow or prompt
	always @(posedge aclk)
		if (prio_req.valid)
		begin
			ch_seen <= prio_req.channel;
			n_req++;
			repeat (lat) @(posedge aclk);
			prio_wr <= {1'h1, pval};
			@(posedge aclk);
			prio_wr <= {1'h0, ~pval};
		end
endmodule

//--- arr_result_regs_asserts.sv
`timescale 1ns/1ps
module arr_result_regs_asserts
#(
	parameter int ADDR_WIDTH = 8
)
(
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic                   s_axi_awvalid,
	input wire logic                   s_axi_awready,
	input wire logic                   s_axi_wvalid,
	input wire logic                   s_axi_wready,
	input wire logic                   s_axi_bvalid,
	input wire logic                   s_axi_bready,
	input wire logic [1:0]             s_axi_bresp,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic                   s_axi_rvalid,
	input wire logic                   s_axi_rready,
	input wire logic [31:0]            s_axi_rdata,
	input wire arr_pkg::arr_prio_req_t prio_req
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer not two cycles after");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed");
	a_arready_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_req_single: assert property (prio_req.valid |=> !prio_req.valid)
		else $error("priority request longer than one cycle");
	a_req_on_write: assert property (prio_req.valid |-> $rose(s_axi_bvalid))
		else $error("priority request without write answer");
endmodule

bind arr_result_regs arr_result_regs_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.aclk,
	.aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .prio_req);

//--- test_adc_result_regs_upper.sv
`timescale 1ns/1ps
module test_adc_result_regs_upper;
	import arr_pkg::*;
	logic          aclk = 1'h0, aresetn = 1'h0;
	logic [7:0]    s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]    s_axi_wstrb = 4'hF, ch;
	logic          s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic          s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]    s_axi_bresp, s_axi_rresp, r;
	logic [9:0]    mv [3], v;
	logic          ms [3], mo [3];
	logic [5:0]    mist = 6'h00, mien = 6'h00;
	arr_norm_wr_t  norm_wr;
	arr_prio_wr_t  prio_wr;
	arr_prio_req_t prio_req;
	int            bad_count = 0, cmp_count = 0;
	arr_result_regs #(.ADDR_WIDTH(8)) u_arr_result_regs (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .norm_wr, .prio_wr, .prio_req, .irq);
	arr_seq_model u_arr_seq_model (.aclk, .prio_req, .norm_wr, .prio_wr);
	always #4 aclk = ~aclk;
	task end_sim;
	begin
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
	begin
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	// both channels offered together, each released when taken
	task wr(input logic [7:0] a, input logic [31:0] w, output logic [1:0] resp);
	begin
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= w;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	end
	endtask
	task rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] resp);
	begin
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		q = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	end
	endtask
	task mconv(input int i, input logic [9:0] x);
	begin
		mist = mist | (6'h1 << (2 * i));
		if (ms[i]) mist = mist | (6'h2 << (2 * i));
		mo[i] = mo[i] | ms[i];
		ms[i] = 1'h1;
		mv[i] = x;
	end
	endtask
	task rres(input int i);
	begin
		rd(8'(4 * i), d, r);
		chk("result", d, {16'h0000, mv[i], 4'h0, mo[i], ms[i]});
		ms[i] = 1'h0;
		mo[i] = 1'h0;
	end
	endtask
	initial
	begin
		#(20000 * 8);
		bad_count++;
		end_sim;
	end
	initial
	begin
		void'($urandom(95));
		foreach (ms[i])
		begin
			ms[i] = 1'h0;
			mo[i] = 1'h0;
			mv[i] = 10'h000;
		end
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 7; i++)
		begin
			rd(8'(4 * i), d, r);
			chk("reset", d, 32'h0);
		end
		$display("reset test done");
		for (int i = 0; i < 2; i++)
		begin
			for (int k = 0; k < 2; k++)
			begin
				v = 10'($urandom);
				u_arr_seq_model.conv(3'h6 + 3'(i), v);
				mconv(i, v);
			end
			u_arr_seq_model.conv(3'h3, 10'($urandom));
			rres(i);
			rres(i);
		end
		rd(8'h0C, d, r);
		chk("status", d, {26'h0, mist});
		wr(8'h10, 32'h3F, r);
		mist = 6'h00;
		rd(8'h0C, d, r);
		chk("status", d, 32'h0);
		$display("normal slot test done");
		for (int j = 0; j < 2; j++)
		begin
			u_arr_seq_model.lat = j ? 5 : 1;
			u_arr_seq_model.pval = 10'($urandom);
			ch = 4'($urandom);
			wr(8'h18, {23'h0, 1'h1, 4'h0, ch}, r);
			if (j == 1) wr(8'h18, {23'h0, 1'h1, 4'h0, ~ch}, r);
			do rd(8'h18, d, r); while (d[9] === 1'h1);
			// the ignored second start still rewrites the channel field
			chk("channel", {28'h0, d[3:0]}, {28'h0, (j == 1) ? ~ch : ch});
			chk("req channel", {28'h0, u_arr_seq_model.ch_seen}, {28'h0, ch});
			mconv(2, u_arr_seq_model.pval);
		end
		chk("req count", 32'(u_arr_seq_model.n_req), 32'h2);
		rres(2);
		$display("priority test done");
		wr(8'h00, $urandom, r);
		chk("ro resp", {30'h0, r}, 32'h0);
		rres(0);
		wr(8'h40, $urandom, r);
		chk("bad wr resp", {30'h0, r}, 32'h2);
		rd(8'h40, d, r);
		chk("bad rd", d, 32'h0);
		chk("bad rd resp", {30'h0, r}, 32'h2);
		$display("access test done");
		mien = 6'($urandom) | 6'h01;
		wr(8'h14, {26'h0, mien}, r);
		rd(8'h14, d, r);
		chk("enable", d, {26'h0, mien});
		v = 10'($urandom);
		u_arr_seq_model.conv(3'h6, v);
		mconv(0, v);
		@(posedge aclk);
		chk("irq", {31'h0, irq}, {31'h0, |(mist & mien)});
		wr(8'h14, 32'h0, r);
		chk("irq masked", {31'h0, irq}, 32'h0);
		wr(8'h10, 32'h3F, r);
		mist = 6'h00;
		wr(8'h14, 32'h3F, r);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		rres(0);
		$display("interrupt test done");
		end_sim;
	end
endmodule
